// [core/fra_pkg.sv]
// constants, field layout and opcode types of the file-register alu block
// assumes one 10 MHz clock and a 32-bit AXI4-Lite register port
package fra_pkg;

  typedef enum logic [2:0] {
    FRA_OP_INC = 3'b000,
    FRA_OP_IOR = 3'b001,
    FRA_OP_LSL = 3'b010,
    FRA_OP_LSR = 3'b011,
    FRA_OP_MOV = 3'b100,
    FRA_OP_IND = 3'b101,
    FRA_OP_REL = 3'b110,
    FRA_OP_NOP = 3'b111
  } fra_op_t;

  // register word indices, byte address is four times the index
  localparam logic [5:0] FRA_IDX_INSTR = 6'h00;
  localparam logic [5:0] FRA_IDX_WREG = 6'h01;
  localparam logic [5:0] FRA_IDX_STATUS = 6'h02;
  localparam logic [5:0] FRA_IDX_PTR0 = 6'h03;
  localparam logic [5:0] FRA_IDX_PTR1 = 6'h04;
  localparam logic [5:0] FRA_IDX_BANK = 6'h05;
  localparam logic [5:0] FRA_IDX_MADDR = 6'h06;
  localparam logic [5:0] FRA_IDX_MDATA = 6'h07;

  // instruction word fields
  localparam int FRA_F_OP_LSB = 0;
  localparam int FRA_F_DEST = 3;
  localparam int FRA_F_PSEL = 4;
  localparam int FRA_F_MODE_LSB = 5;
  localparam int FRA_F_FADDR_LSB = 8;
  localparam int FRA_F_OFS_LSB = 16;
  localparam int FRA_FADDR_W = 7;
  localparam int FRA_OFS_W = 6;
  localparam int FRA_BANK_W = 5;

  // status bits
  localparam int FRA_ST_C = 0;
  localparam int FRA_ST_Z = 1;
  localparam int FRA_ST_BUSY = 2;

  // pointer update modes
  localparam logic [1:0] FRA_MODE_PREINC = 2'b00;
  localparam logic [1:0] FRA_MODE_PREDEC = 2'b01;
  localparam logic [1:0] FRA_MODE_POSTINC = 2'b10;
  localparam logic [1:0] FRA_MODE_POSTDEC = 2'b11;

  // reset values
  localparam logic [31:0] FRA_RST_INSTR = 32'h0000_0007;
  localparam logic [7:0] FRA_RST_WREG = 8'h00;
  localparam logic [15:0] FRA_RST_PTR = 16'h0000;
  localparam logic [4:0] FRA_RST_BANK = 5'h00;
  localparam logic [15:0] FRA_RST_MADDR = 16'h0000;

  localparam logic [1:0] FRA_RESP_OKAY = 2'b00;
  localparam logic [1:0] FRA_RESP_SLVERR = 2'b10;

endpackage

// [core/fra_alu.sv]
// alu of the file-register block, file operand alone or with the working register for or
// assumes the caller registers result and flags
`timescale 1ns/100ps
module fra_alu
  import fra_pkg::*;
(
  input wire fra_op_t op,
  input wire logic [7:0] w_in,
  input wire logic [7:0] f_in,
  output logic [7:0] result,
  output logic carry_out,
  output logic carry_upd,
  output logic zero
);

  always_comb begin
    result = f_in;
    carry_out = 1'b0;
    carry_upd = 1'b0;
    unique case (op)
      FRA_OP_INC: result = 8'(f_in + 8'h01);
      FRA_OP_IOR: result = w_in | f_in;
      FRA_OP_LSL: begin
        result = {f_in[6:0], 1'b0};
        carry_out = f_in[7];
        carry_upd = 1'b1;
      end
      FRA_OP_LSR: begin
        result = {1'b0, f_in[7:1]};
        carry_out = f_in[0];
        carry_upd = 1'b1;
      end
      FRA_OP_MOV, FRA_OP_IND, FRA_OP_REL, FRA_OP_NOP: result = f_in;
    endcase
    zero = (result == 8'h00);
  end

endmodule

// [core/fra_core.sv]
// file-register alu with indirect load, registers on AXI4-Lite
// assumes aclk at 10 MHz and a master keeping AXI4-Lite handshakes
`timescale 1ns/100ps
module fra_core
  import fra_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int DATA_AW = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [7:0] data_mem [0:(1<<DATA_AW)-1];
  logic [31:0] instr_reg;
  logic exec_reg;
  logic [7:0] w_reg;
  logic c_reg;
  logic z_reg;
  logic [15:0] ptr_reg [0:1];
  logic [FRA_BANK_W-1:0] bank_reg;
  logic [15:0] maddr_reg;
  logic awready_reg;
  logic wready_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;

  function automatic logic [DATA_AW-1:0] mem_index(input logic [15:0] a);
    return a[DATA_AW-1:0];
  endfunction

  function automatic logic [15:0] ptr_step(input logic [15:0] p, input logic down);
    return down ? 16'(p - 16'h0001) : 16'(p + 16'h0001);
  endfunction

  function automatic logic [5:0] word_index(input logic [ADDR_W-1:0] a);
    return 6'(a >> 2);
  endfunction

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    return word_index(a) <= FRA_IDX_MDATA;
  endfunction

  function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  // ---------------------------------------------------------------
  // instruction decode and operand fetch
  // ---------------------------------------------------------------
  fra_op_t op;
  logic dest;
  logic psel;
  logic [1:0] mode;
  logic [FRA_FADDR_W-1:0] faddr;
  logic [15:0] ofs16;
  logic [15:0] direct_addr;
  logic [15:0] ptr_cur;
  logic [15:0] ptr_new;
  logic [15:0] eff_addr;
  logic is_ind;
  logic [7:0] mem_rd;
  logic [7:0] alu_res;
  logic alu_c;
  logic alu_cupd;
  logic alu_z;

  assign op = fra_op_t'(instr_reg[FRA_F_OP_LSB +: 3]);
  assign dest = instr_reg[FRA_F_DEST];
  assign psel = instr_reg[FRA_F_PSEL];
  assign mode = instr_reg[FRA_F_MODE_LSB +: 2];
  assign faddr = instr_reg[FRA_F_FADDR_LSB +: FRA_FADDR_W];
  assign ofs16 = {{(16-FRA_OFS_W){instr_reg[FRA_F_OFS_LSB+FRA_OFS_W-1]}},
                  instr_reg[FRA_F_OFS_LSB +: FRA_OFS_W]};
  // bank on top of the 7-bit direct field
  assign direct_addr = {4'h0, bank_reg, faddr};
  assign ptr_cur = ptr_reg[psel];
  assign is_ind = (op == FRA_OP_IND) || (op == FRA_OP_REL);

  always_comb begin
    ptr_new = ptr_cur;
    eff_addr = ptr_cur;
    if (op == FRA_OP_REL) begin
      eff_addr = 16'(ptr_cur + ofs16);
    end else begin
      unique case (mode)
        FRA_MODE_PREINC: begin
          ptr_new = ptr_step(ptr_cur, 1'b0);
          eff_addr = ptr_new;
        end
        FRA_MODE_PREDEC: begin
          ptr_new = ptr_step(ptr_cur, 1'b1);
          eff_addr = ptr_new;
        end
        FRA_MODE_POSTINC: ptr_new = ptr_step(ptr_cur, 1'b0);
        FRA_MODE_POSTDEC: ptr_new = ptr_step(ptr_cur, 1'b1);
      endcase
    end
  end

  // indirect port has no storage, it is the pointed-to location
  assign mem_rd = data_mem[mem_index(is_ind ? eff_addr : direct_addr)];

  fra_alu u_alu (
    .op(op),
    .w_in(w_reg),
    .f_in(mem_rd),
    .result(alu_res),
    .carry_out(alu_c),
    .carry_upd(alu_cupd),
    .zero(alu_z)
  );

  // ---------------------------------------------------------------
  // register bus
  // ---------------------------------------------------------------
  logic wr_fire;
  logic [5:0] wr_idx;
  logic [31:0] wr_val;
  logic [31:0] rd_val;

  function automatic logic [31:0] reg_read(input logic [5:0] idx);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (idx)
      FRA_IDX_INSTR: v = instr_reg;
      FRA_IDX_WREG: v[7:0] = w_reg;
      FRA_IDX_STATUS: begin
        v[FRA_ST_C] = c_reg;
        v[FRA_ST_Z] = z_reg;
        v[FRA_ST_BUSY] = exec_reg;
      end
      FRA_IDX_PTR0: v[15:0] = ptr_reg[0];
      FRA_IDX_PTR1: v[15:0] = ptr_reg[1];
      FRA_IDX_BANK: v[FRA_BANK_W-1:0] = bank_reg;
      FRA_IDX_MADDR: v[15:0] = maddr_reg;
      FRA_IDX_MDATA: v[7:0] = data_mem[mem_index(maddr_reg)];
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  assign wr_fire = !awready_reg && !wready_reg && !bvalid_reg;
  assign wr_idx = word_index(awaddr_reg);

  always_comb begin
    wr_val = merge_strb(reg_read(wr_idx), wdata_reg, wstrb_reg);
    rd_val = reg_read(word_index(s_axi_araddr));
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      bvalid_reg <= 1'b0;
      bresp_reg <= FRA_RESP_OKAY;
      awaddr_reg <= '0;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end else begin
      if (s_axi_awvalid && awready_reg) begin
        awaddr_reg <= s_axi_awaddr;
        awready_reg <= 1'b0;
      end
      if (s_axi_wvalid && wready_reg) begin
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
        wready_reg <= 1'b0;
      end
      if (wr_fire) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= is_mapped(awaddr_reg) ? FRA_RESP_OKAY : FRA_RESP_SLVERR;
      end
      if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= FRA_RESP_OKAY;
    end else if (s_axi_arvalid && arready_reg) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rdata_reg <= is_mapped(s_axi_araddr) ? rd_val : 32'h0000_0000;
      rresp_reg <= is_mapped(s_axi_araddr) ? FRA_RESP_OKAY : FRA_RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  // ---------------------------------------------------------------
  // execution, one cycle after the instruction word is written
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      instr_reg <= FRA_RST_INSTR;
      exec_reg <= 1'b0;
    end else begin
      exec_reg <= wr_fire && (wr_idx == FRA_IDX_INSTR);
      if (wr_fire && wr_idx == FRA_IDX_INSTR) begin
        instr_reg <= wr_val;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_reg <= FRA_RST_WREG;
    end else if (exec_reg && op != FRA_OP_NOP && (is_ind || !dest)) begin
      w_reg <= alu_res;
    end else if (wr_fire && wr_idx == FRA_IDX_WREG) begin
      w_reg <= wr_val[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      c_reg <= 1'b0;
      z_reg <= 1'b0;
    end else if (exec_reg && op != FRA_OP_NOP) begin
      z_reg <= alu_z;
      if (alu_cupd) begin
        c_reg <= alu_c;
      end
    end else if (wr_fire && wr_idx == FRA_IDX_STATUS) begin
      c_reg <= wr_val[FRA_ST_C];
      z_reg <= wr_val[FRA_ST_Z];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ptr_reg[0] <= FRA_RST_PTR;
      ptr_reg[1] <= FRA_RST_PTR;
    end else if (exec_reg && is_ind) begin
      ptr_reg[psel] <= ptr_new;
    end else if (wr_fire && (wr_idx == FRA_IDX_PTR0 || wr_idx == FRA_IDX_PTR1)) begin
      ptr_reg[wr_idx == FRA_IDX_PTR1] <= wr_val[15:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bank_reg <= FRA_RST_BANK;
      maddr_reg <= FRA_RST_MADDR;
    end else if (wr_fire) begin
      if (wr_idx == FRA_IDX_BANK) begin
        bank_reg <= wr_val[FRA_BANK_W-1:0];
      end
      if (wr_idx == FRA_IDX_MADDR) begin
        maddr_reg <= wr_val[15:0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (exec_reg && !is_ind && op != FRA_OP_NOP && dest) begin
      data_mem[mem_index(direct_addr)] <= alu_res;
    end else if (wr_fire && wr_idx == FRA_IDX_MDATA) begin
      data_mem[mem_index(maddr_reg)] <= wr_val[7:0];
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  sequence s_instr_write;
    wr_fire && wr_idx == FRA_IDX_INSTR;
  endsequence

  sequence s_exec_once;
    exec_reg ##1 !exec_reg;
  endsequence

  property p_one_cycle;
    @(posedge aclk) disable iff (!aresetn) s_instr_write |=> s_exec_once;
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("instruction did not run in one cycle");

  property p_inc;
    @(posedge aclk) disable iff (!aresetn)
      exec_reg && op == FRA_OP_INC && !dest |=> w_reg == 8'($past(mem_rd) + 8'h01) && z_reg == ($past(mem_rd) == 8'hff);
  endproperty
  a_inc: assert property (p_inc) else $error("increment result or zero wrong");

  property p_dest_file;
    @(posedge aclk) disable iff (!aresetn)
      exec_reg && !is_ind && op != FRA_OP_NOP && dest |=> w_reg == $past(w_reg);
  endproperty
  a_dest_file: assert property (p_dest_file) else $error("working register changed on file destination");

  property p_ior;
    @(posedge aclk) disable iff (!aresetn)
      exec_reg && op == FRA_OP_IOR && !dest |=> w_reg == ($past(w_reg) | $past(mem_rd));
  endproperty
  a_ior: assert property (p_ior) else $error("or result wrong");

  property p_lsl;
    @(posedge aclk) disable iff (!aresetn)
      exec_reg && op == FRA_OP_LSL |=> c_reg == $past(mem_rd[7]) && z_reg == ($past(mem_rd[6:0]) == 7'h00);
  endproperty
  a_lsl: assert property (p_lsl) else $error("left shift flags wrong");

  property p_lsr;
    @(posedge aclk) disable iff (!aresetn)
      exec_reg && op == FRA_OP_LSR && !dest |=> c_reg == $past(mem_rd[0]) && w_reg[7] == 1'b0;
  endproperty
  a_lsr: assert property (p_lsr) else $error("right shift wrong");

  property p_mov_test;
    @(posedge aclk) disable iff (!aresetn)
      exec_reg && op == FRA_OP_MOV && dest |=> z_reg == ($past(mem_rd) == 8'h00);
  endproperty
  a_mov_test: assert property (p_mov_test) else $error("in-place move did not set zero");

  property p_ind_load;
    @(posedge aclk) disable iff (!aresetn)
      exec_reg && is_ind |=> w_reg == $past(mem_rd) && c_reg == $past(c_reg);
  endproperty
  a_ind_load: assert property (p_ind_load) else $error("indirect load or carry wrong");

  property p_preinc;
    @(posedge aclk) disable iff (!aresetn)
      exec_reg && op == FRA_OP_IND && mode == FRA_MODE_PREINC
        |-> mem_index(eff_addr) == mem_index(16'(ptr_cur + 16'h0001)) ##1 ptr_reg[$past(psel)] == 16'($past(ptr_cur) + 16'h0001);
  endproperty
  a_preinc: assert property (p_preinc) else $error("pre-increment wrong");

  property p_postdec;
    @(posedge aclk) disable iff (!aresetn)
      exec_reg && op == FRA_OP_IND && mode == FRA_MODE_POSTDEC && ptr_cur == 16'h0000
        |=> ptr_reg[$past(psel)] == 16'hffff;
  endproperty
  a_postdec: assert property (p_postdec) else $error("pointer did not wrap");

  property p_rel;
    @(posedge aclk) disable iff (!aresetn)
      exec_reg && op == FRA_OP_REL |=> ptr_reg[$past(psel)] == $past(ptr_cur);
  endproperty
  a_rel: assert property (p_rel) else $error("relative access moved pointer");

endmodule

// [testbench/fra_axi_master.sv]
// register-bus master model driving the fra_core register port
// assumes an AXI4-Lite slave sampled on the rising edge of aclk
`timescale 1ns/100ps
module fra_axi_master (
  input wire logic aclk,
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end

  // --------------------------------------------------
  // single-word write and read
  // --------------------------------------------------
  task automatic wr(input logic [5:0] idx, input logic [31:0] d, output logic [1:0] resp);
    logic done;
    @(posedge aclk);
    awaddr <= {idx, 2'b00};
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      done = bvalid;
      resp = bresp;
    end while (!done);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] idx, output logic [31:0] d, output logic [1:0] resp);
    logic done;
    @(posedge aclk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      done = rvalid;
      d = rdata;
      resp = rresp;
    end while (!done);
    rready <= 1'b0;
  endtask
endmodule

// [testbench/tb_file_reg_alu_indirect_load.sv]
// self-checking bench of the file-register alu, driven over its register port
// assumes fra_core with default widths and the master model beside it
`timescale 1ns/100ps
module tb_file_reg_alu_indirect_load
  import fra_pkg::*;
;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr, ea;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic [15:0] np;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic [7:0] al [7] = '{8'h00, 8'h0f, 8'h10, 8'h11, 8'h5f, 8'hff, 8'h20};

  fra_core u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  fra_axi_master u_master (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready));

  // --------------------------------------------------
  // helpers
  // --------------------------------------------------
  function automatic logic [31:0] ins(fra_op_t op, logic dst, logic ps, logic [1:0] md, logic [6:0] fa,
                                      logic [5:0] ofs);
    return {10'h000, ofs, 1'b0, fa, 1'b0, md, ps, dst, op};
  endfunction

  function automatic logic [7:0] pat(logic [7:0] a);
    return a ^ 8'h5a;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [5:0] idx, input logic [31:0] exp);
    logic [31:0] v;
    logic [1:0] rs;
    u_master.rd(idx, v, rs);
    chk(v, exp);
    chk({30'h0, rs}, {30'h0, FRA_RESP_OKAY});
  endtask

  task automatic wreg(input logic [5:0] idx, input logic [31:0] v);
    logic [1:0] rs;
    u_master.wr(idx, v, rs);
    chk({30'h0, rs}, {30'h0, FRA_RESP_OKAY});
  endtask

  task automatic exec(input fra_op_t op, input logic dst, input logic ps, input logic [1:0] md,
                      input logic [6:0] fa, input logic [5:0] ofs);
    wreg(FRA_IDX_INSTR, ins(op, dst, ps, md, fa, ofs));
  endtask

  task automatic mset(input logic [7:0] a, input logic [7:0] v);
    wreg(FRA_IDX_MADDR, {24'h000000, a});
    wreg(FRA_IDX_MDATA, {24'h000000, v});
  endtask

  task automatic mchk(input logic [7:0] a, input logic [7:0] exp);
    wreg(FRA_IDX_MADDR, {24'h000000, a});
    rd_chk(FRA_IDX_MDATA, {24'h000000, exp});
  endtask

  task automatic test_done();
    if (n_mismatch == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // --------------------------------------------------
  // clock, reset and timeout
  // --------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      n_mismatch++;
      test_done();
    end
  end

  // --------------------------------------------------
  // main sequence
  // --------------------------------------------------
  initial begin
    aresetn = 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(FRA_IDX_INSTR, FRA_RST_INSTR);
    rd_chk(FRA_IDX_WREG, 32'h0);
    rd_chk(FRA_IDX_STATUS, 32'h0);
    rd_chk(FRA_IDX_PTR1, 32'h0);
    u_master.rd(6'h08, d, r);
    chk(d, 32'h0);
    chk({30'h0, r}, {30'h0, FRA_RESP_SLVERR});
    u_master.wr(6'h08, 32'h1, r);
    chk({30'h0, r}, {30'h0, FRA_RESP_SLVERR});
    // increment with wrap, both destinations, banked address
    wreg(FRA_IDX_BANK, 32'h1);
    mset(8'h85, 8'hff);
    exec(FRA_OP_INC, 1'b0, 1'b0, 2'b00, 7'h05, 6'h00);
    rd_chk(FRA_IDX_WREG, 32'h0);
    rd_chk(FRA_IDX_STATUS, 32'h2);
    mchk(8'h85, 8'hff);
    exec(FRA_OP_INC, 1'b1, 1'b0, 2'b00, 7'h05, 6'h00);
    mchk(8'h85, 8'h00);
    exec(FRA_OP_INC, 1'b1, 1'b0, 2'b00, 7'h05, 6'h00);
    mchk(8'h85, 8'h01);
    rd_chk(FRA_IDX_STATUS, 32'h0);
    rd_chk(FRA_IDX_WREG, 32'h0);
    // inclusive or at the top direct address
    wreg(FRA_IDX_BANK, 32'h0);
    mset(8'h7f, 8'h05);
    wreg(FRA_IDX_WREG, 32'h30);
    exec(FRA_OP_IOR, 1'b0, 1'b0, 2'b00, 7'h7f, 6'h00);
    rd_chk(FRA_IDX_WREG, 32'h35);
    exec(FRA_OP_IOR, 1'b1, 1'b0, 2'b00, 7'h7f, 6'h00);
    mchk(8'h7f, 8'h35);
    // shifts into carry, zero shifted in
    mset(8'h7f, 8'h81);
    exec(FRA_OP_LSL, 1'b0, 1'b0, 2'b00, 7'h7f, 6'h00);
    rd_chk(FRA_IDX_WREG, 32'h02);
    rd_chk(FRA_IDX_STATUS, 32'h1);
    mset(8'h7f, 8'h80);
    exec(FRA_OP_LSL, 1'b1, 1'b0, 2'b00, 7'h7f, 6'h00);
    mchk(8'h7f, 8'h00);
    rd_chk(FRA_IDX_STATUS, 32'h3);
    mset(8'h7f, 8'h01);
    exec(FRA_OP_LSR, 1'b0, 1'b0, 2'b00, 7'h7f, 6'h00);
    rd_chk(FRA_IDX_WREG, 32'h00);
    rd_chk(FRA_IDX_STATUS, 32'h3);
    mset(8'h7f, 8'h82);
    exec(FRA_OP_LSR, 1'b1, 1'b0, 2'b00, 7'h7f, 6'h00);
    mchk(8'h7f, 8'h41);
    rd_chk(FRA_IDX_STATUS, 32'h0);
    // move tests a register in place
    mset(8'h7f, 8'h00);
    exec(FRA_OP_MOV, 1'b1, 1'b0, 2'b00, 7'h7f, 6'h00);
    rd_chk(FRA_IDX_STATUS, 32'h2);
    mchk(8'h7f, 8'h00);
    wreg(FRA_IDX_STATUS, 32'h1);
    mset(8'h7f, 8'h9c);
    exec(FRA_OP_MOV, 1'b0, 1'b0, 2'b00, 7'h7f, 6'h00);
    rd_chk(FRA_IDX_WREG, 32'h9c);
    rd_chk(FRA_IDX_STATUS, 32'h1);
    // indirect loads, every pointer mode, carry kept set
    foreach (al[i]) mset(al[i], pat(al[i]));
    for (int m = 0; m < 4; m++) begin
      wreg(FRA_IDX_PTR0, 32'h10);
      exec(FRA_OP_IND, 1'b1, 1'b0, m[1:0], 7'h00, 6'h00);
      ea = (m == 0) ? 8'h11 : (m == 1) ? 8'h0f : 8'h10;
      np = m[0] ? 16'h000f : 16'h0011;
      rd_chk(FRA_IDX_WREG, {24'h0, pat(ea)});
      rd_chk(FRA_IDX_PTR0, {16'h0, np});
      rd_chk(FRA_IDX_STATUS, 32'h1);
    end
    wreg(FRA_IDX_PTR1, 32'hffff);
    exec(FRA_OP_IND, 1'b0, 1'b1, FRA_MODE_PREINC, 7'h00, 6'h00);
    rd_chk(FRA_IDX_WREG, {24'h0, pat(8'h00)});
    rd_chk(FRA_IDX_PTR1, 32'h0);
    exec(FRA_OP_IND, 1'b0, 1'b1, FRA_MODE_POSTDEC, 7'h00, 6'h00);
    rd_chk(FRA_IDX_PTR1, 32'hffff);
    rd_chk(FRA_IDX_PTR0, 32'h0f);
    // relative offset at both ends of its range
    mset(8'h20, 8'h00);
    wreg(FRA_IDX_PTR0, 32'h40);
    exec(FRA_OP_REL, 1'b0, 1'b0, 2'b00, 7'h00, 6'h20);
    rd_chk(FRA_IDX_WREG, 32'h0);
    rd_chk(FRA_IDX_STATUS, 32'h3);
    exec(FRA_OP_REL, 1'b0, 1'b0, 2'b00, 7'h00, 6'h1f);
    rd_chk(FRA_IDX_WREG, {24'h0, pat(8'h5f)});
    rd_chk(FRA_IDX_PTR0, 32'h40);
    rd_chk(FRA_IDX_STATUS, 32'h1);
    // nop leaves data, working register, flags and pointers alone
    exec(FRA_OP_NOP, 1'b1, 1'b0, 2'b00, 7'h7f, 6'h00);
    mchk(8'h7f, 8'h9c);
    rd_chk(FRA_IDX_WREG, {24'h0, pat(8'h5f)});
    rd_chk(FRA_IDX_STATUS, 32'h1);
    rd_chk(FRA_IDX_PTR0, 32'h40);
    // reset in mid-run brings registers back to their reset values
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(FRA_IDX_WREG, 32'h0);
    rd_chk(FRA_IDX_PTR0, 32'h0);
    rd_chk(FRA_IDX_STATUS, 32'h0);
    rd_chk(FRA_IDX_INSTR, FRA_RST_INSTR);
    test_done();
  end
endmodule
